// file: nvc_defs.svh
`ifndef NVC_DEFS_SVH
`define NVC_DEFS_SVH
`define NVC_NV_BYTES     512
`define NVC_BANK_SIZE    563
`define NVC_BANK_LAST    17'h00232
`define NVC_SEG_BASE     13'ha00
`define NVC_SEG_SIZE     23
`define NVC_SEG_LAST     13'ha16
`define NVC_STATUS_ADDR  13'hb00
`define NVC_ERROR_ADDR   13'hb01
`define NVC_WE_ADDR      13'hb02
`define NVC_SAVE_ADDR    13'hb03
`define NVC_SOFTRST_ADDR 13'h000
`define NVC_SOFTRST_BIT  5
`define NVC_COMMIT_ADDR  13'h232
`define NVC_COMMIT_BIT   0
`define NVC_WE_BIT       0
`define NVC_SOFTLD_BIT   1
`define NVC_SAVE_BIT     0
`define NVC_VCO_IDX      10'h018
`define NVC_VCO_BIT      0
`define NVC_RDSRC_IDX    10'h004
`define NVC_OP_COMMIT    8'h80
`define NVC_OP_END       8'hff
`define NVC_OP_PEND      8'hfe
`define NVC_REG0_DEFAULT 8'h18
`define NVC_REG_DEFAULT  8'h00
`define NVC_FIFO_DEPTH   8
`define NVC_CLK_NS       10
`define NVC_NV_WR_NS     40
`define NVC_NV_WR_CYC    ((`NVC_NV_WR_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS)
`define NVC_SEG_DEFAULT  {8'h7f, 8'h00, 8'h00, 8'h7f, 8'h80, 8'h00, \
  8'h7f, 8'h00, 8'h01, 8'h7f, 8'h80, 8'h01, 8'h31, 8'h00, 8'h02, \
  8'h80, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff}
`endif

// file: nvc_pkg.sv
`default_nettype none
package nvc_pkg;
  typedef enum {ST_IDLE, SV_OP, SV_HDR, SV_DAT, SV_DRAIN,
                LD_OP, LD_HDR, LD_DAT, ST_FIN} nvc_state_e;
  typedef logic [7:0] nvc_byte_t;
endpackage : nvc_pkg
`default_nettype wire

// file: nvc_fifo.sv
`default_nettype none
module nvc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_sys_rst,
  // Fill side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // Drain side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [0:D-1];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic          push;
  logic          pop;

  assign o_in_ready  = (cnt != (AW+1)'(D));
  assign o_out_valid = (cnt != '0);
  assign o_out_data  = mem[rp];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_ff @(posedge i_ref_clk)
  begin
    if (push)
      mem[wp] <= i_in_data;
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end
    else
    begin
      if (push)
        wp <= (wp == AW'(D-1)) ? '0 : wp + 1'b1;
      if (pop)
        rp <= (rp == AW'(D-1)) ? '0 : rp + 1'b1;
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : nvc_fifo
`default_nettype wire

// file: nvc_ctrl.sv
// Summary of operation
// - Nonvolatile store is 512 bytes, never overrun.
// - Refuse register access while busy, except status.
// - Transfer flag set at start, cleared at end.
// - I2C address acknowledged only when idle.
// - Status pin mirrors transfer flag when selected.
// - No direct serial path into the store.
// - Commit during save request with write enable set starts the save.
// - Hardware clears save request when save finishes.
// - Error bit reports transfer outcome.
// - Load select high: load on reset events.
// - Load select low: soft load bit loads.
// - Load select low at reset: use defaults.
// - Stored calibrate bit starts calibration after load.
// - Default segment lists registers 0x000 to 0x231; its save overruns the store and errors.
// - Segment is groups interleaved with operation codes.
// - Group is three bytes, count minus one.
// - Group address is low byte, then high.
// - Writes go to buffer; commit copies all.
// - Code 0x80 commits buffer into active bank.
// - Code 0xFF ends save or load.
// - Code 0xFE pauses save, keeps store address.
`include "nvc_defs.svh"
`default_nettype none
module nvc_ctrl
  import nvc_pkg::*;
(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  // Pins
  input  wire logic        i_load_sel,
  input  wire logic        i_status_sel,
  input  wire logic        i_i2c_addr_hit,
  // Register port from the serial front end
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [12:0] i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  output logic             o_reg_rvalid,
  output logic             o_reg_refused,
  // Status
  output logic             o_status_pin,
  output logic             o_i2c_ack,
  output logic             o_i2c_nack,
  output logic             o_vco_cal_start
);
  // ****************************************************************
  // Storage
  // ****************************************************************
  nvc_byte_t  buf_bank [0:`NVC_BANK_SIZE-1];
  nvc_byte_t  act_bank [0:`NVC_BANK_SIZE-1];
  nvc_byte_t  seg      [0:`NVC_SEG_SIZE-1];
  nvc_byte_t  nv_mem   [0:`NVC_NV_BYTES-1];
  localparam logic [8*`NVC_SEG_SIZE-1:0] SEG_INIT = `NVC_SEG_DEFAULT;

  nvc_state_e  st;
  logic        xfer;
  logic        err;
  logic        we;
  logic        save_req;
  logic        por_pend;
  logic        pend;
  logic        is_load;
  logic [4:0]  sp;
  logic [1:0]  hb;
  logic [6:0]  cnt;
  logic [15:0] raddr;
  logic [9:0]  np;
  logic        ovf;
  logic        commit_ld;
  logic [16:0] gend;

  // ****************************************************************
  // Host access decode
  // ****************************************************************
  logic       acc;
  logic       wr_ok;
  logic       in_bank;
  logic       in_seg;
  logic [4:0] seg_idx;
  logic       host_commit;
  logic       soft_rst;
  logic       soft_load;
  logic       start_load;
  logic       start_save;
  logic       def_load;

  assign acc       = !xfer || (i_reg_rd && !i_reg_wr
                     && i_reg_addr == `NVC_STATUS_ADDR);
  assign wr_ok     = i_reg_wr && !xfer;
  assign in_bank   = ({4'h0, i_reg_addr} <= `NVC_BANK_LAST);
  assign in_seg    = (i_reg_addr >= `NVC_SEG_BASE)
                     && (i_reg_addr <= `NVC_SEG_LAST);
  assign seg_idx   = 5'(i_reg_addr - `NVC_SEG_BASE);
  assign host_commit = wr_ok && i_reg_addr == `NVC_COMMIT_ADDR
                       && i_reg_wdata[`NVC_COMMIT_BIT];
  assign soft_rst  = wr_ok && i_reg_addr == `NVC_SOFTRST_ADDR
                     && i_reg_wdata[`NVC_SOFTRST_BIT];
  assign soft_load = wr_ok && i_reg_addr == `NVC_WE_ADDR
                     && i_reg_wdata[`NVC_SOFTLD_BIT];
  assign start_load = (i_load_sel && (por_pend || soft_rst))
                      || (!i_load_sel && soft_load);
  assign start_save = host_commit && save_req && we;
  assign def_load   = !i_load_sel && soft_rst;

  // The strap is sampled at the first edge after release, never in reset.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      por_pend <= 1'b1;
    else
      por_pend <= 1'b0;
  end

  // ****************************************************************
  // Register banks
  // ****************************************************************
  logic [9:0] bidx;
  nvc_byte_t  nb;
  logic       ld_wr;

  assign bidx  = i_reg_addr[9:0];
  assign nb    = nv_mem[np[8:0]];
  assign ld_wr = (st == LD_DAT) && !np[9] && (gend <= `NVC_BANK_LAST);

  // Defaults come back both at reset and on a soft reset without load.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      for (int i = 0; i < `NVC_BANK_SIZE; i++)
      begin
        buf_bank[i] <= (i == 0) ? `NVC_REG0_DEFAULT : `NVC_REG_DEFAULT;
        act_bank[i] <= (i == 0) ? `NVC_REG0_DEFAULT : `NVC_REG_DEFAULT;
      end
    end
    else if (def_load)
    begin
      for (int i = 0; i < `NVC_BANK_SIZE; i++)
      begin
        buf_bank[i] <= (i == 0) ? `NVC_REG0_DEFAULT : `NVC_REG_DEFAULT;
        act_bank[i] <= (i == 0) ? `NVC_REG0_DEFAULT : `NVC_REG_DEFAULT;
      end
    end
    else
    begin
      // The soft reset bit clears itself, so it never sticks in the bank.
      if (wr_ok && in_bank && i_reg_addr != `NVC_COMMIT_ADDR)
        buf_bank[bidx] <= (i_reg_addr == `NVC_SOFTRST_ADDR)
                          ? (i_reg_wdata & ~(8'h01 << `NVC_SOFTRST_BIT))
                          : i_reg_wdata;
      if (ld_wr)
        buf_bank[raddr[9:0]] <= nb;
      if (host_commit || commit_ld)
      begin
        for (int i = 0; i < `NVC_BANK_SIZE; i++)
          act_bank[i] <= buf_bank[i];
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      for (int i = 0; i < `NVC_SEG_SIZE; i++)
        seg[i] <= SEG_INIT[8*(`NVC_SEG_SIZE-1-i) +: 8];
    end
    else if (wr_ok && in_seg)
      seg[seg_idx] <= i_reg_wdata;
  end

  // ****************************************************************
  // Save path through the FIFO into the store
  // ****************************************************************
  localparam int DIV_W = $clog2(`NVC_NV_WR_CYC + 1);
  logic [DIV_W-1:0] div;
  logic       wr_tick;
  logic       push_v;
  nvc_byte_t  push_d;
  logic       f_rdy;
  logic       f_val;
  nvc_byte_t  f_dat;
  logic       pop;
  nvc_byte_t  sb;
  logic       sp_ok;

  // The store accepts one byte per write slot; the FIFO absorbs the gap.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      div <= '0;
    else if (wr_tick)
      div <= '0;
    else
      div <= div + 1'b1;
  end
  assign wr_tick = (div == DIV_W'(`NVC_NV_WR_CYC - 1));
  assign pop     = f_val && wr_tick;

  nvc_fifo #(
    .W (8),
    .D (`NVC_FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (push_v),
    .i_in_data   (push_d),
    .o_in_ready  (f_rdy),
    .o_out_valid (f_val),
    .o_out_data  (f_dat),
    .i_out_ready (wr_tick)
  );

  // Only the save sequence reaches the store; there is no host path.
  always_ff @(posedge i_ref_clk)
  begin
    if (pop && !np[9] && we)
      nv_mem[np[8:0]] <= f_dat;
  end

  assign sp_ok = (sp < 5'(`NVC_SEG_SIZE));
  assign sb    = sp_ok ? seg[sp] : `NVC_OP_END;
  assign gend  = {1'b0, raddr} + 17'(cnt);

  always_comb
  begin
    push_v = 1'b0;
    push_d = sb;
    unique case (st)
      SV_OP:
        push_v = !ovf && sp_ok && (sb == `NVC_OP_END
                 || sb == `NVC_OP_COMMIT);
      SV_HDR:
      begin
        push_v = 1'b1;
        push_d = seg[5'(sp + 5'(hb))];
      end
      SV_DAT:
      begin
        push_v = !ovf && (gend <= `NVC_BANK_LAST);
        push_d = act_bank[raddr[9:0]];
      end
      default:
        push_v = 1'b0;
    endcase
  end

  // ****************************************************************
  // Transfer sequencer
  // ****************************************************************
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st        <= ST_IDLE;
      xfer      <= 1'b0;
      err       <= 1'b0;
      we        <= 1'b0;
      save_req  <= 1'b0;
      pend      <= 1'b0;
      is_load   <= 1'b0;
      sp        <= '0;
      hb        <= '0;
      cnt       <= '0;
      raddr     <= '0;
      np        <= '0;
      ovf       <= 1'b0;
      commit_ld <= 1'b0;
      o_vco_cal_start <= 1'b0;
    end
    else
    begin
      commit_ld       <= 1'b0;
      o_vco_cal_start <= 1'b0;
      if (wr_ok && i_reg_addr == `NVC_WE_ADDR)
        we <= i_reg_wdata[`NVC_WE_BIT];
      if (wr_ok && i_reg_addr == `NVC_SAVE_ADDR)
        save_req <= i_reg_wdata[`NVC_SAVE_BIT];
      if (pop)
      begin
        if (np[9])
          ovf <= 1'b1;
        else
          np <= np + 1'b1;
      end
      unique case (st)
        ST_IDLE:
        begin
          pend <= 1'b0;
          if (start_load)
          begin
            st      <= LD_OP;
            xfer    <= 1'b1;
            err     <= 1'b0;
            is_load <= 1'b1;
            np      <= '0;
          end
          else if (start_save)
          begin
            st      <= SV_OP;
            xfer    <= 1'b1;
            err     <= 1'b0;
            is_load <= 1'b0;
            sp      <= '0;
            ovf     <= 1'b0;
          end
        end
        SV_OP:
        begin
          if (ovf || !sp_ok)
          begin
            err <= 1'b1;
            st  <= SV_DRAIN;
          end
          else if (sb == `NVC_OP_PEND)
          begin
            pend <= 1'b1;
            st   <= SV_DRAIN;
          end
          else if (sb == `NVC_OP_END)
          begin
            if (f_rdy)
              st <= SV_DRAIN;
          end
          else if (sb == `NVC_OP_COMMIT)
          begin
            if (f_rdy)
              sp <= sp + 1'b1;
          end
          else if (sb[7] || sp > 5'(`NVC_SEG_SIZE - 3))
          begin
            err <= 1'b1;
            st  <= SV_DRAIN;
          end
          else
          begin
            cnt <= sb[6:0];
            hb  <= '0;
            st  <= SV_HDR;
          end
        end
        SV_HDR:
        begin
          if (f_rdy)
          begin
            hb <= hb + 1'b1;
            if (hb == 2'd2)
            begin
              raddr <= {seg[5'(sp + 5'd2)], seg[5'(sp + 5'd1)]};
              sp    <= sp + 5'd3;
              st    <= SV_DAT;
            end
          end
        end
        SV_DAT:
        begin
          if (ovf || gend > `NVC_BANK_LAST)
          begin
            err <= 1'b1;
            st  <= SV_DRAIN;
          end
          else if (f_rdy)
          begin
            raddr <= raddr + 1'b1;
            cnt   <= cnt - 1'b1;
            if (cnt == '0)
              st <= SV_OP;
          end
        end
        SV_DRAIN:
        begin
          if (!f_val)
          begin
            err <= err | ovf;
            st  <= ST_FIN;
          end
        end
        LD_OP:
        begin
          if (np[9])
          begin
            err <= 1'b1;
            st  <= ST_FIN;
          end
          else if (nb == `NVC_OP_END)
            st <= ST_FIN;
          else if (nb == `NVC_OP_COMMIT || nb == `NVC_OP_PEND)
          begin
            commit_ld <= (nb == `NVC_OP_COMMIT);
            np        <= np + 1'b1;
          end
          else if (nb[7])
          begin
            err <= 1'b1;
            st  <= ST_FIN;
          end
          else
          begin
            cnt <= nb[6:0];
            hb  <= '0;
            np  <= np + 1'b1;
            st  <= LD_HDR;
          end
        end
        LD_HDR:
        begin
          if (np[9])
          begin
            err <= 1'b1;
            st  <= ST_FIN;
          end
          else
          begin
            np <= np + 1'b1;
            hb <= hb + 1'b1;
            if (hb == 2'd0)
              raddr[7:0] <= nb;
            else
            begin
              raddr[15:8] <= nb;
              st          <= LD_DAT;
            end
          end
        end
        LD_DAT:
        begin
          if (np[9] || gend > `NVC_BANK_LAST)
          begin
            err <= 1'b1;
            st  <= ST_FIN;
          end
          else
          begin
            np    <= np + 1'b1;
            raddr <= raddr + 1'b1;
            cnt   <= cnt - 1'b1;
            if (cnt == '0)
              st <= LD_OP;
          end
        end
        ST_FIN:
        begin
          xfer <= 1'b0;
          st   <= ST_IDLE;
          if (!is_load)
            save_req <= 1'b0;
          if (!pend)
            np <= '0;
          if (is_load && !err)
            o_vco_cal_start <=
              act_bank[`NVC_VCO_IDX][`NVC_VCO_BIT];
        end
      endcase
    end
  end

  // ****************************************************************
  // Readback and pin outputs
  // ****************************************************************
  nvc_byte_t rd_mux;

  always_comb
  begin
    rd_mux = 8'h00;
    if (in_bank)
      rd_mux = act_bank[`NVC_RDSRC_IDX][0] ? act_bank[bidx]
                                           : buf_bank[bidx];
    else if (in_seg)
      rd_mux = seg[seg_idx];
    else if (i_reg_addr == `NVC_STATUS_ADDR)
      rd_mux = {7'h00, xfer};
    else if (i_reg_addr == `NVC_ERROR_ADDR)
      rd_mux = {7'h00, err};
    else if (i_reg_addr == `NVC_WE_ADDR)
      rd_mux = {7'h00, we};
    else if (i_reg_addr == `NVC_SAVE_ADDR)
      rd_mux = {7'h00, save_req};
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_reg_rdata   <= 8'h00;
      o_reg_rvalid  <= 1'b0;
      o_reg_refused <= 1'b0;
      o_status_pin  <= 1'b0;
      o_i2c_ack     <= 1'b0;
      o_i2c_nack    <= 1'b0;
    end
    else
    begin
      o_reg_rvalid  <= i_reg_rd && !i_reg_wr && acc;
      o_reg_refused <= (i_reg_rd || i_reg_wr) && !acc;
      if (i_reg_rd && !i_reg_wr && acc)
        o_reg_rdata <= rd_mux;
      o_status_pin  <= i_status_sel && xfer;
      o_i2c_ack     <= i_i2c_addr_hit && !xfer;
      o_i2c_nack    <= i_i2c_addr_hit && xfer;
    end
  end
endmodule : nvc_ctrl
`default_nettype wire

// file: nvc_ctrl_sva.sv
`include "nvc_defs.svh"
`default_nettype none
module nvc_ctrl_sva (
  // Clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  // Pins
  input wire logic        i_load_sel,
  input wire logic        i_status_sel,
  input wire logic        i_i2c_addr_hit,
  // Register port
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [12:0] i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic [7:0]  o_reg_rdata,
  input wire logic        o_reg_rvalid,
  input wire logic        o_reg_refused,
  // Status
  input wire logic        o_status_pin,
  input wire logic        o_i2c_ack,
  input wire logic        o_i2c_nack,
  input wire logic        o_vco_cal_start
);
  // ****
  // Port relations
  // ****
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);
  a_read_answered: assert property (
    i_reg_rd && !i_reg_wr |=> o_reg_rvalid != o_reg_refused)
    else $error("read got no single answer");
  a_status_open: assert property (
    i_reg_rd && !i_reg_wr && i_reg_addr == `NVC_STATUS_ADDR |=> o_reg_rvalid)
    else $error("status read refused");
  a_refuse_busy: assert property (
    i_status_sel ##1 o_reg_refused |-> o_status_pin)
    else $error("refusal while idle");
  a_status_data: assert property (
    i_reg_rd && !i_reg_wr && i_reg_addr == `NVC_STATUS_ADDR && i_status_sel
    |=> o_reg_rdata[0] == o_status_pin)
    else $error("status bit and pin disagree");
  a_pin_off: assert property (
    !i_status_sel |=> !o_status_pin)
    else $error("status pin driven while unselected");
  a_i2c_single: assert property (
    i_i2c_addr_hit |=> o_i2c_ack != o_i2c_nack)
    else $error("address hit without single answer");
  a_i2c_busy: assert property (
    i_i2c_addr_hit && i_status_sel |=> o_i2c_nack == o_status_pin)
    else $error("acknowledge does not follow transfer flag");
  a_i2c_cause: assert property (
    o_i2c_ack || o_i2c_nack |-> $past(i_i2c_addr_hit))
    else $error("answer without address hit");
  a_vco_pulse: assert property (
    o_vco_cal_start |=> !o_vco_cal_start)
    else $error("calibration start longer than a pulse");
  c_refused: cover property (o_reg_refused);
  c_nack: cover property (o_i2c_nack);
  c_vco: cover property (o_vco_cal_start);
  c_busy_pin: cover property (o_status_pin [*8]);
endmodule : nvc_ctrl_sva
bind nvc_ctrl nvc_ctrl_sva u_sva (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_load_sel(i_load_sel),
  .i_status_sel(i_status_sel), .i_i2c_addr_hit(i_i2c_addr_hit),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid), .o_reg_refused(o_reg_refused),
  .o_status_pin(o_status_pin), .o_i2c_ack(o_i2c_ack),
  .o_i2c_nack(o_i2c_nack), .o_vco_cal_start(o_vco_cal_start));
`default_nettype wire

// file: nvc_host.sv
`include "nvc_defs.svh"
`default_nettype none
module nvc_host (
  // Clock
  input  wire logic        i_ref_clk,
  // Register port toward the device
  output logic             o_reg_wr,
  output logic             o_reg_rd,
  output logic      [12:0] o_reg_addr,
  output logic      [7:0]  o_reg_wdata,
  input  wire logic [7:0]  i_reg_rdata,
  input  wire logic        i_reg_rvalid,
  input  wire logic        i_reg_refused
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Host accesses
  // ****
  initial
  begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 13'h0000;
    o_reg_wdata = 8'h00;
  end
  // A random idle gap stands in for a slow host.
  task automatic xfer(input logic w, input logic [12:0] a,
                      input logic [7:0] d, output logic [7:0] q,
                      output logic rf);
    logic ok;
    repeat ($urandom_range(3)) @(negedge i_ref_clk);
    @(negedge i_ref_clk);
    o_reg_wr = w;
    o_reg_rd = !w;
    o_reg_addr = a;
    o_reg_wdata = d;
    @(negedge i_ref_clk);
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    // A released bus shows the inverse, so a stale value never matches.
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
    ok = i_reg_rvalid;
    rf = i_reg_refused;
    @(negedge i_ref_clk);
    ok = ok | i_reg_rvalid;
    rf = rf | i_reg_refused;
    q = ok ? i_reg_rdata : 8'hxx;
  endtask : xfer
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       rf;
    xfer(1'b1, a, d, q, rf);
  endtask : wr
  task automatic rd(input logic [12:0] a, output logic [7:0] q,
                    output logic rf);
    xfer(1'b0, a, 8'h00, q, rf);
  endtask : rd
  task automatic save();
    wr(`NVC_WE_ADDR, 8'h01);
    wr(`NVC_SAVE_ADDR, 8'h01);
    wr(`NVC_COMMIT_ADDR, 8'h01);
  endtask : save
  task automatic wait_idle(output logic [7:0] st);
    logic rf;
    int   n;
    n = 0;
    st = 8'hff;
    while (st[0] !== 1'b0 && n < 5000)
    begin
      rd(`NVC_STATUS_ADDR, st, rf);
      n++;
    end
    wr(`NVC_WE_ADDR, 8'h00);
    repeat (1000) @(negedge i_ref_clk);
  endtask : wait_idle
endmodule : nvc_host
`default_nettype wire

// file: nvc_ctrl_tb.sv
`include "nvc_defs.svh"
`default_nettype none
module nvc_ctrl_tb
  import nvc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 128;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        load_sel = 1'b0;
  logic        status_sel = 1'b1;
  logic        hit = 1'b0;
  logic        reg_wr, reg_rd, rvalid, refused, pin, ack, nack, vco, rf;
  logic [12:0] addr;
  nvc_byte_t   wdata, rdata, q;
  nvc_byte_t   val [N];
  nvc_byte_t   seg [$];
  int          errors = 0;
  int          checked = 0;
  int          vco_seen = 0;

  always #5 clk = ~clk;
  always @(negedge clk) if (vco) vco_seen++;

  nvc_ctrl u_dut (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_load_sel(load_sel),
    .i_status_sel(status_sel), .i_i2c_addr_hit(hit), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_reg_refused(refused),
    .o_status_pin(pin), .o_i2c_ack(ack), .o_i2c_nack(nack),
    .o_vco_cal_start(vco));
  nvc_host u_host (
    .i_ref_clk(clk), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
    .o_reg_addr(addr), .o_reg_wdata(wdata), .i_reg_rdata(rdata),
    .i_reg_rvalid(rvalid), .i_reg_refused(refused));

  // ****
  // Helpers
  // ****
  task automatic complete_run();
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  task automatic check(input string what, input nvc_byte_t seen,
                       input nvc_byte_t exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rchk(input string what, input logic [12:0] a,
                      input nvc_byte_t exp);
    u_host.rd(a, q, rf);
    check(what, q, exp);
  endtask : rchk
  task automatic probe(input logic exp_ack);
    logic a;
    logic n;
    @(negedge clk);
    hit = 1'b1;
    @(negedge clk);
    hit = 1'b0;
    a = ack;
    n = nack;
    @(negedge clk);
    check("i2c ack", {7'h00, a | ack}, {7'h00, exp_ack});
    check("i2c nack", {7'h00, n | nack}, {7'h00, !exp_ack});
  endtask : probe
  task automatic reset_pulse();
    @(negedge clk);
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
  endtask : reset_pulse
  task automatic put_seg();
    foreach (seg[i]) u_host.wr(13'ha00 + 13'(i), seg[i]);
  endtask : put_seg
  // A save fails once the image outgrows the store.
  function automatic logic exp_fail(input int data, input int groups);
    return (data + 3 * groups + 2) > `NVC_NV_BYTES;
  endfunction : exp_fail

  // ****
  // Scenarios
  // ****
  initial
  begin
    void'($urandom(32'h20ace30b));
    repeat (10) @(negedge clk);
    rst = 1'b0;
    rchk("reg0 default", 13'h000, `NVC_REG0_DEFAULT);
    rchk("flag idle", `NVC_STATUS_ADDR, 8'h00);
    // Largest legal group, with the calibrate register inside it.
    seg = '{8'(N - 1), 8'h10, 8'h00, `NVC_OP_COMMIT, `NVC_OP_END};
    put_seg();
    foreach (val[i]) val[i] = nvc_byte_t'($urandom);
    val[8][0] = 1'b1;
    foreach (val[i]) u_host.wr(13'h010 + 13'(i), val[i]);
    u_host.save();
    probe(1'b0);
    check("pin busy", {7'h00, pin}, 8'h01);
    u_host.xfer(1'b1, 13'h011, 8'h00, q, rf);
    check("wr refused", {7'h00, rf}, 8'h01);
    rchk("flag busy", `NVC_STATUS_ADDR, 8'h01);
    u_host.wait_idle(q);
    check("flag done", {7'h00, q[0]}, 8'h00);
    probe(1'b1);
    rchk("save req", `NVC_SAVE_ADDR, 8'h00);
    rchk("save err", `NVC_ERROR_ADDR, {7'h00, exp_fail(N, 1)});
    u_host.wr(13'h004, 8'h01);
    foreach (val[i]) u_host.wr(13'h010 + 13'(i), ~val[i]);
    u_host.wr(`NVC_COMMIT_ADDR, 8'h01);
    rchk("commit", 13'h012, ~val[2]);
    u_host.wr(`NVC_WE_ADDR, 8'h02);
    u_host.wait_idle(q);
    foreach (val[i]) rchk("soft load", 13'h010 + 13'(i), val[i]);
    check("vco once", 8'(vco_seen), 8'h01);
    load_sel = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      if (k == 0)
        reset_pulse();
      else
        u_host.wr(`NVC_SOFTRST_ADDR, 8'h20);
      rchk("flag load", `NVC_STATUS_ADDR, 8'h01);
      u_host.wait_idle(q);
      rchk("reload", 13'h018, val[8]);
    end
    check("vco again", 8'(vco_seen), 8'h03);
    load_sel = 1'b0;
    u_host.wr(`NVC_SOFTRST_ADDR, 8'h20);
    rchk("defaults", 13'h018, `NVC_REG_DEFAULT);
    status_sel = 1'b0;
    // The default image overruns the store; a bad count byte stops early.
    for (int k = 0; k < 2; k++)
    begin
      reset_pulse();
      seg = '{8'h90};
      if (k == 1)
        put_seg();
      u_host.save();
      u_host.wait_idle(q);
      rchk("error", `NVC_ERROR_ADDR,
           {7'h00, k == 1 || exp_fail(`NVC_BANK_SIZE - 1, 5)});
      rchk("flag end", `NVC_STATUS_ADDR, 8'h00);
    end
    // A pseudo-end halts the save; the next save resumes behind it.
    u_host.wr(13'h030, val[0]);
    u_host.wr(13'h031, val[1]);
    for (int k = 0; k < 2; k++)
    begin
      if (k == 0)
        seg = '{8'h00, 8'h30, 8'h00, `NVC_OP_PEND};
      else
        seg = '{8'h00, 8'h31, 8'h00, `NVC_OP_COMMIT, `NVC_OP_END};
      put_seg();
      u_host.save();
      u_host.wait_idle(q);
      rchk("pause req", `NVC_SAVE_ADDR, 8'h00);
      rchk("pause err", `NVC_ERROR_ADDR, 8'h00);
    end
    u_host.wr(13'h030, ~val[0]);
    u_host.wr(13'h031, ~val[1]);
    u_host.wr(`NVC_WE_ADDR, 8'h02);
    u_host.wait_idle(q);
    rchk("resume lo", 13'h030, val[0]);
    rchk("resume hi", 13'h031, val[1]);
    complete_run();
  end

  initial
  begin
    #400000;
    errors++;
    complete_run();
  end
endmodule : nvc_ctrl_tb
`default_nettype wire
